// ### core/irq_fifo_pkg.sv
// shared constants for the interrupt and fifo status block
package irq_fifo_pkg;
	// register offsets (host port addresses)
	localparam logic [5:0] ADDR_IRQ_MAIN   = 6'h00;
	localparam logic [5:0] ADDR_IRQ_TIMER  = 6'h01;
	localparam logic [5:0] ADDR_IRQ_ERROR  = 6'h02;
	localparam logic [5:0] ADDR_IRQ_TARGET = 6'h03;
	localparam logic [5:0] ADDR_MASK_BASE  = 6'h04;
	localparam logic [5:0] ADDR_FIFO_STAT1 = 6'h08;
	localparam logic [5:0] ADDR_FIFO_STAT2 = 6'h09;
	localparam logic [5:0] ADDR_FIFO_DATA  = 6'h0A;
	localparam logic [5:0] ADDR_COMMAND    = 6'h0B;
	localparam logic [5:0] ADDR_BIT_RATE   = 6'h0C;
	localparam logic [5:0] ADDR_CONTROL    = 6'h0D;
	// number of interrupt registers
	localparam int NUM_IRQ_REGS = 4;
	// command codes written to the command register
	localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
	localparam logic [7:0] CMD_STOP_ALL    = 8'hC2;
	localparam logic [7:0] CMD_CLEAR_FIFO  = 8'hDB;
	// fifo status 2 field positions
	localparam int FIFO_OVF_BIT = 5;
	localparam int FIFO_UNF_BIT = 4;
	// bit positions inside the interrupt registers
	localparam int MAIN_RXS_BIT      = 5;
	localparam int MAIN_RXE_BIT      = 4;
	localparam int MAIN_TXE_BIT      = 3;
	localparam int MAIN_WL_BIT       = 6;
	localparam int TIMER_EON_BIT     = 4;
	localparam int TIMER_RATE_BIT    = 3;
	localparam int TIMER_CAT_BIT     = 2;
	localparam int TIMER_CAC_BIT     = 1;
	localparam int ERROR_PPON_BIT    = 7;
	localparam int TARGET_SLOT_BIT   = 7;
	// control register bit positions
	localparam int CTRL_ENABLE_BIT  = 7;
	localparam int CTRL_RX_EN_BIT   = 6;
	localparam int CTRL_FD_EN_BIT   = 1;
	// fifo depth and slot figures
	localparam int FIFO_DEPTH       = 512;
	localparam int SLOT_COUNT       = 24;
	localparam logic [4:0] SLOT_LOW_LEVEL = 5'h04;
	// low power wake confirmation window
	localparam int  CLOCK_MHZ        = 125;
	localparam int  WAKE_CONFIRM_MS  = 10;
	localparam int  WAKE_CONFIRM_CYC = WAKE_CONFIRM_MS * CLOCK_MHZ * 1000;
	// reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
endpackage

// ### core/byte_fifo.sv
// byte fifo with overflow and underflow detection
`timescale 1ns/1ps
module byte_fifo #(
	parameter int DEPTH = 512
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// pointer reset
	input  wire logic       clear,
	// write side
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	// read side
	input  wire logic       rd_en,
	output logic      [7:0] rd_data,
	// status
	output logic      [9:0] count,
	output logic            overflow,
	output logic            underflow
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0]    mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [9:0]    count_reg;
	logic [7:0]    rd_data_reg;
	logic          ovf_reg;
	logic          unf_reg;
	wire           full  = (count_reg == 10'(DEPTH));
	wire           empty = (count_reg == 10'h000);
	wire           do_wr = wr_en && !full;
	wire           do_rd = rd_en && !empty;

	// storage, no reset needed on the array
	always_ff @(posedge clock) begin
		if (do_wr) begin
			mem_reg[wr_ptr_reg] <= wr_data;
		end
	end

	// pointers and flags; clear beats any access in the same cycle
	always_ff @(posedge clock) begin
		if (!rst_n || clear) begin
			wr_ptr_reg  <= '0;
			rd_ptr_reg  <= '0;
			count_reg   <= 10'h000;
			rd_data_reg <= 8'h00;
			ovf_reg     <= 1'b0;
			unf_reg     <= 1'b0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + 10'(do_wr) - 10'(do_rd);
			// empty reads show zero
			if (rd_en) begin
				rd_data_reg <= do_rd ? mem_reg[rd_ptr_reg] : 8'h00;
			end
			if (wr_en && full) begin
				ovf_reg <= 1'b1;
			end
			if (rd_en && empty) begin
				unf_reg <= 1'b1;
			end
		end
	end

	assign rd_data   = rd_data_reg;
	assign count     = count_reg;
	assign overflow  = ovf_reg;
	assign underflow = unf_reg;
endmodule

// ### core/wait_timer.sv
// one-shot down counter with a timeout pulse
`timescale 1ns/1ps
module wait_timer #(
	parameter int WIDTH = 24
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// control
	input  wire logic             start,
	input  wire logic             cancel,
	input  wire logic [WIDTH-1:0] load,
	// status
	output logic                  running,
	output logic                  expired
);
	logic [WIDTH-1:0] count_reg;
	logic             run_reg;
	logic             exp_reg;

	// start reloads; cancel stops without a timeout pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_reg <= '0;
			run_reg   <= 1'b0;
			exp_reg   <= 1'b0;
		end else begin
			exp_reg <= 1'b0;
			if (start) begin
				count_reg <= load;
				run_reg   <= 1'b1;
			end else if (cancel) begin
				run_reg <= 1'b0;
			end else if (run_reg) begin
				if (count_reg <= WIDTH'(1)) begin
					run_reg <= 1'b0;
					exp_reg <= 1'b1;
				end else begin
					count_reg <= count_reg - 1'b1;
				end
			end
		end
	end

	assign running = run_reg;
	assign expired = exp_reg;
endmodule

// ### core/irq_and_fifo_status.sv
// interrupt status, masking and fifo status logic facing the host
//
// Functional notes
// - events set status bit, unmasked raise irq
// - four interrupt registers, main distinguishes sources
// - reading a status register clears it
// - irq drops after last pending bit read
// - mask blocks irq, status still set
// - reads return and clear masked bits too
// - unmasking a pending bit raises irq at once
// - commands and reads clear irq and status
// - 512-byte data fifo for transmit and receive
// - overflow on write while fifo full
// - underflow on read while fifo empty
// - both flags held in fifo status 2
// - fifo reset at receive start, reset, set-default and clear-fifo commands
// - empty fifo reads return zero
// - response field timeout raises its interrupt
// - guard time elapsed flags cat or cac
// - bit rate detected raises irq, rate readable
// - field wake raises irq, host confirms 10 ms
// - four slot numbers left raises interrupt
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module irq_and_fifo_status
	import irq_fifo_pkg::*;
#(
	parameter int FIFO_BYTES   = FIFO_DEPTH,
	parameter int WAKE_CYCLES  = WAKE_CONFIRM_CYC,
	parameter int TIMER_WIDTH  = 24
) (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	// host register port
	input  wire logic [5:0]             reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_write,
	input  wire logic                   reg_read,
	output logic      [7:0]             reg_rdata,
	// interrupt output to host
	output logic                        irq,
	// generic event sources from the rest of the device
	input  wire logic                   rx_start,
	input  wire logic                   rx_end,
	input  wire logic                   tx_end,
	input  wire logic                   water_level,
	// receive and transmit data paths
	input  wire logic                   rx_byte_valid,
	input  wire logic [7:0]             rx_byte,
	input  wire logic                   tx_byte_req,
	output logic      [7:0]             tx_byte,
	// active target listen events
	input  wire logic                   own_field_off,
	input  wire logic                   ext_field,
	input  wire logic [TIMER_WIDTH-1:0] response_field_wait_timer,
	input  wire logic                   guard_done,
	input  wire logic                   guard_collision,
	// bit rate detection
	input  wire logic                   bitrate_detect_select,
	input  wire logic [1:0]             detected_rate,
	// low power field detection
	input  wire logic                   low_power_detect,
	output logic                        wake_osc_rx,
	// slot number consumption
	input  wire logic                   slot_used,
	input  wire logic                   slot_reload
);
	// per-register event vectors and storage
	logic [7:0] status_reg [NUM_IRQ_REGS];
	logic [7:0] mask_reg   [NUM_IRQ_REGS];
	logic [7:0] event_vec  [NUM_IRQ_REGS];
	logic [NUM_IRQ_REGS-1:0] pend_any;
	logic [7:0] rdata_reg;
	logic [7:0] ctrl_reg;
	logic [1:0] rate_reg;
	logic       rate_seen_reg;
	logic [4:0] slots_left_reg;
	logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_reg;
	logic       wake_reg;
	logic       ext_field_d_reg;

	// address decode helper used by the read data select
	function automatic logic is_irq_addr(input logic [5:0] a);
		return a < 6'(NUM_IRQ_REGS);
	endfunction

	wire        cmd_wr       = reg_write && (reg_addr == ADDR_COMMAND);
	wire        cmd_default  = cmd_wr && (reg_wdata == CMD_SET_DEFAULT);
	wire        cmd_stop     = cmd_wr && (reg_wdata == CMD_STOP_ALL);
	wire        cmd_clrfifo  = cmd_wr && (reg_wdata == CMD_CLEAR_FIFO);
	wire        clear_all    = cmd_default || cmd_stop || cmd_clrfifo;
	wire        fifo_clear   = rx_start || cmd_default || cmd_clrfifo;
	wire        host_fifo_wr = reg_write && (reg_addr == ADDR_FIFO_DATA);
	wire        host_fifo_rd = reg_read && (reg_addr == ADDR_FIFO_DATA);

	// fifo: host writes or receiver fills; host reads or transmitter drains
	wire        fifo_wr      = host_fifo_wr || rx_byte_valid;
	wire [7:0]  fifo_wdata   = rx_byte_valid ? rx_byte : reg_wdata;
	wire        fifo_rd      = host_fifo_rd || tx_byte_req;
	logic [7:0] fifo_rdata;
	logic [9:0] fifo_count;
	logic       fifo_ovf;
	logic       fifo_unf;

	byte_fifo #(
		.DEPTH(FIFO_BYTES)
	) u_fifo (
		.clock    (clock),
		.rst_n    (rst_n),
		.clear    (fifo_clear),
		.wr_en    (fifo_wr),
		.wr_data  (fifo_wdata),
		.rd_en    (fifo_rd),
		.rd_data  (fifo_rdata),
		.count    (fifo_count),
		.overflow (fifo_ovf),
		.underflow(fifo_unf)
	);
	assign tx_byte = fifo_rdata;

	// response field wait: started when our own field goes off
	logic rfw_running;
	logic rfw_expired;
	wire  rfw_start  = own_field_off && ctrl_reg[CTRL_FD_EN_BIT];
	wire  rfw_cancel = ext_field;

	wait_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_rfw_timer (
		.clock  (clock),
		.rst_n  (rst_n),
		.start  (rfw_start),
		.cancel (rfw_cancel),
		.load   (response_field_wait_timer),
		.running(rfw_running),
		.expired(rfw_expired)
	);
	wire  response_field_timeout_irq = rfw_expired && !ext_field;

	// rising edge of the external field marks a wake or field-on event
	wire  field_rise   = ext_field && !ext_field_d_reg;
	wire  rate_event   = bitrate_detect_select && rx_start && !rate_seen_reg;
	wire  slot_low_irq = slot_used && (slots_left_reg == SLOT_LOW_LEVEL + 5'h01);

	// event sources grouped per register
	always_comb begin
		for (int i = 0; i < NUM_IRQ_REGS; i++) begin
			event_vec[i] = 8'h00;
		end
		event_vec[0][MAIN_RXS_BIT]      = rx_start;
		event_vec[0][MAIN_RXE_BIT]      = rx_end;
		event_vec[0][MAIN_TXE_BIT]      = tx_end;
		event_vec[0][MAIN_WL_BIT]       = water_level;
		event_vec[1][TIMER_EON_BIT]     = field_rise;
		event_vec[1][TIMER_RATE_BIT]    = rate_event;
		event_vec[1][TIMER_CAT_BIT]     = guard_done && !guard_collision;
		event_vec[1][TIMER_CAC_BIT]     = guard_done && guard_collision;
		event_vec[2][ERROR_PPON_BIT]    = response_field_timeout_irq;
		event_vec[3][TARGET_SLOT_BIT]   = slot_low_irq;
	end
	// any event this cycle, used by the checks below
	wire any_event = |{event_vec[0], event_vec[1], event_vec[2], event_vec[3]};

	// status and mask registers; an event in the read cycle survives
	genvar g;
	generate
		for (g = 0; g < NUM_IRQ_REGS; g++) begin : g_irq
			wire rd_this = reg_read && (reg_addr == 6'(g));
			wire wr_mask = reg_write && (reg_addr == ADDR_MASK_BASE + 6'(g));
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					status_reg[g] <= 8'h00;
				end else if (clear_all) begin
					status_reg[g] <= event_vec[g];
				end else if (rd_this) begin
					status_reg[g] <= event_vec[g];
				end else begin
					status_reg[g] <= status_reg[g] | event_vec[g];
				end
			end
			always_ff @(posedge clock) begin
				if (!rst_n || cmd_default) begin
					mask_reg[g] <= MASK_RESET;
				end else if (wr_mask) begin
					mask_reg[g] <= reg_wdata;
				end
			end
			// a newly cleared mask bit exposes a pending bit at once
			assign pend_any[g] = |(status_reg[g] & ~mask_reg[g]);
		end
	endgenerate

	assign irq = |pend_any;

	// control, rate capture, slot level, field edge
	always_ff @(posedge clock) begin
		if (!rst_n || cmd_default) begin
			ctrl_reg        <= 8'h00;
			rate_reg        <= 2'h0;
			rate_seen_reg   <= 1'b0;
			slots_left_reg  <= 5'(SLOT_COUNT);
			ext_field_d_reg <= 1'b0;
		end else begin
			ext_field_d_reg <= ext_field;
			if (reg_write && reg_addr == ADDR_CONTROL) begin
				ctrl_reg <= reg_wdata;
			end
			if (!bitrate_detect_select) begin
				rate_seen_reg <= 1'b0;
			end else if (rate_event) begin
				rate_reg      <= detected_rate;
				rate_seen_reg <= 1'b1;
			end
			if (slot_reload) begin
				slots_left_reg <= 5'(SLOT_COUNT);
			end else if (slot_used && slots_left_reg != 5'h00) begin
				slots_left_reg <= slots_left_reg - 5'h01;
			end
		end
	end

	// low power wake: oscillator and receiver held on until confirmed or window ends
	wire host_confirmed = ctrl_reg[CTRL_ENABLE_BIT] && ctrl_reg[CTRL_RX_EN_BIT];
	wire wake_last      = wake_cnt_reg == ($bits(wake_cnt_reg))'(WAKE_CYCLES - 1);
	wire wake_done      = host_confirmed || wake_last;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wake_reg     <= 1'b0;
			wake_cnt_reg <= '0;
		end else if (low_power_detect && field_rise) begin
			wake_reg     <= 1'b1;
			wake_cnt_reg <= '0;
		end else if (wake_reg) begin
			if (wake_done) begin
				wake_reg <= 1'b0;
			end
			wake_cnt_reg <= wake_cnt_reg + 1'b1;
		end
	end
	assign wake_osc_rx = wake_reg;

	// read data select, presented the cycle after the read strobe
	logic [7:0] rsel;
	always_comb begin
		rsel = 8'h00;
		if (is_irq_addr(reg_addr)) begin
			rsel = status_reg[reg_addr[1:0]];
		end else if (reg_addr >= ADDR_MASK_BASE && reg_addr < ADDR_FIFO_STAT1) begin
			rsel = mask_reg[reg_addr[1:0]];
		end else if (reg_addr == ADDR_FIFO_STAT1) begin
			rsel = fifo_count[7:0];
		end else if (reg_addr == ADDR_FIFO_STAT2) begin
			rsel = 8'h00;
			rsel[FIFO_OVF_BIT] = fifo_ovf;
			rsel[FIFO_UNF_BIT] = fifo_unf;
			rsel[1:0] = fifo_count[9:8];
		end else if (reg_addr == ADDR_BIT_RATE) begin
			rsel = {6'h00, rate_reg};
		end else if (reg_addr == ADDR_CONTROL) begin
			rsel = ctrl_reg;
		end
	end

	// fifo data comes straight from the fifo output register
	logic fifo_rd_d_reg;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_reg     <= 8'h00;
			fifo_rd_d_reg <= 1'b0;
		end else begin
			fifo_rd_d_reg <= host_fifo_rd;
			rdata_reg     <= reg_read ? rsel : 8'h00;
		end
	end
	assign reg_rdata = fifo_rd_d_reg ? fifo_rdata : rdata_reg;

	// checks
	chk_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
		reg_read && reg_addr == ADDR_IRQ_MAIN && event_vec[0] == 8'h00 && !clear_all
		|=> status_reg[0] == 8'h00)
		else $error("status not cleared by read");
	chk_irq_unmasked: assert property (@(posedge clock) disable iff (!rst_n)
		rx_end && !mask_reg[0][MAIN_RXE_BIT] && !reg_write |=> irq)
		else $error("unmasked event did not raise irq");
	// a lone masked event: status lands while irq stays low
	sequence s_masked_event;
		tx_end && mask_reg[0] == (8'h01 << MAIN_TXE_BIT) && !irq && !reg_write
			&& event_vec[0] == (8'h01 << MAIN_TXE_BIT) && !(|event_vec[1])
			&& !(|event_vec[2]) && !(|event_vec[3]);
	endsequence
	chk_mask_blocks: assert property (@(posedge clock) disable iff (!rst_n)
		s_masked_event |=> status_reg[0][MAIN_TXE_BIT] && !irq)
		else $error("masked bit raised irq");
	chk_cmd_clears: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_stop && event_vec[2] == 8'h00 |=> status_reg[2] == 8'h00)
		else $error("command did not clear status");
	chk_ovf_set: assert property (@(posedge clock) disable iff (!rst_n)
		fifo_wr && fifo_count == 10'(FIFO_BYTES) && !fifo_clear |=> fifo_ovf)
		else $error("overflow not flagged");
	chk_unf_set: assert property (@(posedge clock) disable iff (!rst_n)
		fifo_rd && fifo_count == 10'h000 && !fifo_clear |=> fifo_unf)
		else $error("underflow not flagged");
	chk_fifo_reset: assert property (@(posedge clock) disable iff (!rst_n)
		fifo_clear |=> fifo_count == 10'h000 && !fifo_ovf && !fifo_unf)
		else $error("fifo not reset");
	chk_empty_zero: assert property (@(posedge clock) disable iff (!rst_n)
		host_fifo_rd && fifo_count == 10'h000 && !fifo_clear |=> reg_rdata == 8'h00)
		else $error("empty fifo read not zero");
	chk_rate_irq: assert property (@(posedge clock) disable iff (!rst_n)
		rate_event && !clear_all |=> status_reg[1][TIMER_RATE_BIT] && rate_reg == $past(detected_rate))
		else $error("rate event not captured");
	chk_timeout_irq: assert property (@(posedge clock) disable iff (!rst_n)
		response_field_timeout_irq && !clear_all |=> status_reg[2][ERROR_PPON_BIT])
		else $error("response timeout not flagged");
	// unmasking a pending bit must raise irq on the next edge
	sequence s_unmask_pending;
		reg_write && reg_addr == ADDR_MASK_BASE && !reg_wdata[MAIN_TXE_BIT]
			&& mask_reg[0][MAIN_TXE_BIT] && status_reg[0][MAIN_TXE_BIT] && !reg_read;
	endsequence
	chk_unmask_raises: assert property (@(posedge clock) disable iff (!rst_n)
		s_unmask_pending |=> irq)
		else $error("unmasked pending bit did not raise irq");
	// reading the only register with pending bits lets irq fall
	sequence s_last_read;
		reg_read && reg_addr == ADDR_IRQ_MAIN && pend_any[0]
			&& pend_any[NUM_IRQ_REGS-1:1] == '0 && !any_event && !reg_write;
	endsequence
	chk_irq_drops: assert property (@(posedge clock) disable iff (!rst_n)
		s_last_read |=> !irq)
		else $error("irq stayed high after last read");
	// listen side checks
	chk_guard_flags: assert property (@(posedge clock) disable iff (!rst_n)
		guard_done && !clear_all |=> ($past(guard_collision) ? status_reg[1][TIMER_CAC_BIT]
		: status_reg[1][TIMER_CAT_BIT]))
		else $error("guard time flag missing");
	chk_slot_level: assert property (@(posedge clock) disable iff (!rst_n)
		slot_used && !slot_reload && !clear_all && slots_left_reg == SLOT_LOW_LEVEL + 5'h01
		|=> status_reg[3][TARGET_SLOT_BIT] && slots_left_reg == SLOT_LOW_LEVEL)
		else $error("slot low level not flagged");
	// wake window: opened by a field edge, closed by confirm or timeout
	chk_wake_sets: assert property (@(posedge clock) disable iff (!rst_n)
		low_power_detect && field_rise && !clear_all
		|=> wake_osc_rx && status_reg[1][TIMER_EON_BIT])
		else $error("field wake not raised");
	chk_wake_ends: assert property (@(posedge clock) disable iff (!rst_n)
		wake_reg && wake_done && !(low_power_detect && field_rise) |=> !wake_osc_rx)
		else $error("wake held past confirm or window");
endmodule

// ### testbench/host_model.sv
// host side register master model for the status block
`timescale 1ns/1ps
module host_model
	import irq_fifo_pkg::*;
(
	// clock
	input  wire logic       clock,
	// register port
	output logic      [5:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_write,
	output logic            reg_read,
	input  wire logic [7:0] reg_rdata,
	// interrupt line
	input  wire logic       irq
);
	// bus idle from time zero
	initial begin
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// one-cycle write strobe beside address and data
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
		v = reg_rdata;
	endtask

	// bounded wait, a lost frame must not hang the host
	task automatic wait_irq(output logic ok);
		ok = 1'b0;
		repeat (100) begin
			@(posedge clock);
			if (irq === 1'b1) begin
				ok = 1'b1;
				break;
			end
		end
	endtask

	// confirm a field wake at once, far inside the window
	task automatic confirm_wake();
		wr(ADDR_CONTROL, 8'hC2);
	endtask
endmodule

// ### testbench/irq_and_fifo_status_bench.sv
// self-checking bench for the interrupt and fifo status block
`timescale 1ns/1ps
module irq_and_fifo_status_bench;
	import irq_fifo_pkg::*;
	// event pulse masks, one bit per event input
	localparam logic [9:0] EV_RXS = 10'h001, EV_RXE = 10'h002, EV_TXE = 10'h004;
	localparam logic [9:0] EV_WL = 10'h008, EV_OFF = 10'h010, EV_GRD = 10'h020;
	localparam logic [9:0] EV_SLU = 10'h040, EV_SLR = 10'h080, EV_TXR = 10'h100;
	localparam logic [9:0] EV_RXV = 10'h200;
	// stimulus and observed signals
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [9:0]  ev = 10'h000;
	logic [7:0]  rx_byte = 8'h00;
	logic        ext_field = 1'b0;
	logic [23:0] timer_load = 24'h000014;
	logic        guard_collision = 1'b0;
	logic        rate_sel = 1'b0;
	logic [1:0]  rate = 2'h0;
	logic        low_power = 1'b0;
	logic [5:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [7:0]  reg_rdata;
	logic        irq;
	logic [7:0]  tx_byte;
	logic        wake;
	logic [7:0]  d;
	logic        ok;
	int          errors = 0;
	int          n_checks = 0;

	// design with a short wake window
	irq_and_fifo_status #(.WAKE_CYCLES(50)) i_dut (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
		.rx_start(ev[0]), .rx_end(ev[1]), .tx_end(ev[2]), .water_level(ev[3]),
		.rx_byte_valid(ev[9]), .rx_byte(rx_byte), .tx_byte_req(ev[8]), .tx_byte(tx_byte),
		.own_field_off(ev[4]), .ext_field(ext_field), .response_field_wait_timer(timer_load),
		.guard_done(ev[5]), .guard_collision(guard_collision),
		.bitrate_detect_select(rate_sel), .detected_rate(rate),
		.low_power_detect(low_power), .wake_osc_rx(wake),
		.slot_used(ev[6]), .slot_reload(ev[7])
	);

	// host stands on the register port
	host_model u_host (
		.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq)
	);

	// 8 ns clock
	always #4 clock = ~clock;

	function automatic logic [7:0] bit8(input int b);
		return 8'h01 << b;
	endfunction

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// masked read and compare
	task automatic rdc(input string w, input logic [5:0] a, input logic [7:0] e,
			input logic [7:0] m = 8'hFF);
		u_host.rd(a, d);
		check(w, d & m, e);
	endtask

	task automatic chk_irq(input logic e);
		check("irq", {7'h00, irq}, {7'h00, e});
	endtask

	// one-cycle event pulse, then let the status land
	task automatic pulse(input logic [9:0] m);
		@(posedge clock);
		ev <= m;
		@(posedge clock);
		ev <= 10'h000;
		repeat (2) @(posedge clock);
		#1;
	endtask

	task automatic t_irq();
		pulse(EV_RXE | EV_WL);
		chk_irq(1'b1);
		rdc("main", ADDR_IRQ_MAIN, bit8(MAIN_WL_BIT) | bit8(MAIN_RXE_BIT));
		chk_irq(1'b0);
		rdc("main cleared", ADDR_IRQ_MAIN, 8'h00);
		pulse(EV_TXE | EV_GRD);
		rdc("main txe", ADDR_IRQ_MAIN, bit8(MAIN_TXE_BIT));
		chk_irq(1'b1);
		rdc("timer cat", ADDR_IRQ_TIMER, bit8(TIMER_CAT_BIT));
		chk_irq(1'b0);
		guard_collision <= 1'b1;
		pulse(EV_GRD);
		guard_collision <= 1'b0;
		rdc("timer cac", ADDR_IRQ_TIMER, bit8(TIMER_CAC_BIT));
		$display("t_irq done");
	endtask

	task automatic t_mask();
		u_host.wr(ADDR_MASK_BASE, bit8(MAIN_TXE_BIT));
		pulse(EV_TXE);
		chk_irq(1'b0);
		rdc("masked", ADDR_IRQ_MAIN, bit8(MAIN_TXE_BIT));
		rdc("masked cleared", ADDR_IRQ_MAIN, 8'h00);
		pulse(EV_TXE);
		chk_irq(1'b0);
		u_host.wr(ADDR_MASK_BASE, 8'h00);
		#1;
		chk_irq(1'b1);
		rdc("unmasked", ADDR_IRQ_MAIN, bit8(MAIN_TXE_BIT));
		chk_irq(1'b0);
		$display("t_mask done");
	endtask

	task automatic t_cmds();
		logic [7:0] cmds [3] = '{CMD_STOP_ALL, CMD_CLEAR_FIFO, CMD_SET_DEFAULT};
		foreach (cmds[i]) begin
			pulse(EV_RXE);
			chk_irq(1'b1);
			u_host.wr(ADDR_COMMAND, cmds[i]);
			#1;
			chk_irq(1'b0);
			rdc("after command", ADDR_IRQ_MAIN, 8'h00);
		end
		$display("t_cmds done");
	endtask

	// fill to the brim, overrun, clear, underrun, then the receive path
	task automatic t_fifo();
		logic [7:0] rxb [2] = '{8'hA5, 8'h5A};
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			u_host.wr(ADDR_FIFO_DATA, 8'(i));
		end
		rdc("count low", ADDR_FIFO_STAT1, 8'h00);
		rdc("full", ADDR_FIFO_STAT2, 8'h02, 8'h33);
		u_host.wr(ADDR_FIFO_DATA, 8'hEE);
		rdc("overflow", ADDR_FIFO_STAT2, 8'h22, 8'h33);
		rdc("first byte", ADDR_FIFO_DATA, 8'h00);
		rdc("second byte", ADDR_FIFO_DATA, 8'h01);
		u_host.wr(ADDR_COMMAND, CMD_CLEAR_FIFO);
		rdc("cleared", ADDR_FIFO_STAT2, 8'h00, 8'h33);
		rdc("empty data", ADDR_FIFO_DATA, 8'h00);
		rdc("underflow", ADDR_FIFO_STAT2, 8'h10, 8'h33);
		pulse(EV_RXS);
		rdc("rx start", ADDR_FIFO_STAT2, 8'h00, 8'h33);
		rdc("main rxs", ADDR_IRQ_MAIN, bit8(MAIN_RXS_BIT));
		foreach (rxb[i]) begin
			rx_byte <= rxb[i];
			pulse(EV_RXV);
		end
		pulse(EV_TXR);
		check("tx byte", tx_byte, 8'hA5);
		rdc("rx byte", ADDR_FIFO_DATA, 8'h5A);
		rdc("drained", ADDR_FIFO_STAT1, 8'h00);
		$display("t_fifo done");
	endtask

	task automatic t_listen();
		u_host.wr(ADDR_CONTROL, bit8(CTRL_FD_EN_BIT));
		// own field off stands for the end-of-transmit timer trigger
		pulse(EV_OFF);
		u_host.wait_irq(ok);
		check("timeout irq", {7'h00, ok}, 8'h01);
		rdc("timeout", ADDR_IRQ_ERROR, bit8(ERROR_PPON_BIT));
		pulse(EV_OFF);
		ext_field <= 1'b1;
		repeat (40) @(posedge clock);
		ext_field <= 1'b0;
		rdc("field seen", ADDR_IRQ_ERROR, 8'h00);
		rdc("field edge", ADDR_IRQ_TIMER, bit8(TIMER_EON_BIT));
		rate_sel <= 1'b1;
		rate <= 2'h2;
		pulse(EV_RXS);
		rate_sel <= 1'b0;
		rdc("rate irq", ADDR_IRQ_TIMER, bit8(TIMER_RATE_BIT));
		rdc("rate value", ADDR_BIT_RATE, 8'h02, 8'h03);
		rdc("clear rxs", ADDR_IRQ_MAIN, bit8(MAIN_RXS_BIT));
		low_power <= 1'b1;
		ext_field <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk_irq(1'b1);
		check("wake", {7'h00, wake}, 8'h01);
		rdc("field on", ADDR_IRQ_TIMER, bit8(TIMER_EON_BIT), bit8(TIMER_EON_BIT));
		u_host.confirm_wake();
		low_power <= 1'b0;
		ext_field <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		check("wake off", {7'h00, wake}, 8'h00);
		$display("t_listen done");
	endtask

	// slots run down to the low level
	task automatic t_slot();
		pulse(EV_SLR);
		repeat (SLOT_COUNT - 5) pulse(EV_SLU);
		rdc("five left", ADDR_IRQ_TARGET, 8'h00);
		pulse(EV_SLU);
		rdc("four left", ADDR_IRQ_TARGET, bit8(TARGET_SLOT_BIT));
		$display("t_slot done");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_irq();
		t_mask();
		t_cmds();
		t_fifo();
		t_listen();
		t_slot();
		end_of_test();
	end

	// watchdog, about 35 times the expected run
	initial begin
		#400000;
		errors++;
		end_of_test();
	end
endmodule
